/* pkg/xcvr_port_pkg.sv */
// Package with the variant codes, transmit symbols and reset values of the transceiver serial port.
package xcvr_port_pkg;

  // Interface variants selectable by the static configuration input.
  typedef enum logic [1:0]
  {
    DATA_ZERO_BIDIR = 2'h0,
    DATA_ZERO_UNIDIR = 2'h1,
    LINE_LEVEL_BIDIR = 2'h2,
    LINE_LEVEL_UNIDIR = 2'h3
  } variant_t;

  // Line symbols the controller asks to transmit.
  typedef enum logic [1:0]
  {
    SYM_J = 2'h0,
    SYM_K = 2'h1,
    SYM_ZERO = 2'h2
  } tx_symbol_t;

  localparam logic [1:0] VARIANT_RESET = 2'h1;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 2;

endpackage : xcvr_port_pkg

/* verilog/xcvr_serial_port.sv */
// Pin-level serial port between the link controller and an external full-speed transceiver.
//
// Functional notes
// - Transmit enable output is low while transmitting, high while receiving, in every variant.
// - Data-zero unidirectional: transmit data appears on the data pin while enable is low.
// - Data-zero unidirectional: zero pin requests single-ended zero while enable is low.
// - Line-level bidirectional: shared plus pin is driven out when low, received when high.
// - Line-level bidirectional: shared minus pin is driven out when low, received when high.
// - Line-level unidirectional: device drives plus level while enable is low.
// - Line-level unidirectional: device drives minus level while enable is low.
// - Four variants: data-zero three or six wires, line-level four or six wires.
// - Data-zero three-wire: zero pin carries request out, received zero indication in.
`timescale 1ns/1ps
`default_nettype none

module xcvr_serial_port
  import xcvr_port_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Static configuration.
  input wire logic [1:0] variant_sel,
  // Transmit stream from the controller.
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [1:0] tx_symbol,
  input wire logic tx_last,
  // Receive state to the controller.
  output logic rx_plus,
  output logic rx_minus,
  output logic rx_diff,
  output logic rx_zero,
  output logic [1:0] variant_active,
  output logic tx_busy,
  // Transceiver pins; enables are low while the device drives.
  output logic xcvr_tx_enable_n,
  input wire logic xcvr_data_plus_pin_in,
  output logic xcvr_data_plus_pin_out,
  output logic xcvr_data_plus_pin_oe_n,
  input wire logic xcvr_zero_minus_pin_in,
  output logic xcvr_zero_minus_pin_out,
  output logic xcvr_zero_minus_pin_oe_n,
  input wire logic xcvr_rx_plus_in,
  input wire logic xcvr_rx_minus_in,
  input wire logic xcvr_rx_diff_in
);
  import xcvr_port_pkg::*;

  logic [1:0] buf_sym_q [BUF_DEPTH];
  logic buf_last_q [BUF_DEPTH];
  logic [1:0] buf_cnt_q;
  logic buf_pop;
  logic [1:0] variant_q;
  logic active_q;
  logic plus_q;
  logic minus_q;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] pins_raw;

  // Variant tests used in several places.
  function automatic logic is_line_level(input logic [1:0] v);
    is_line_level = (v == LINE_LEVEL_BIDIR) || (v == LINE_LEVEL_UNIDIR);
  endfunction : is_line_level

  function automatic logic is_bidir(input logic [1:0] v);
    is_bidir = (v == DATA_ZERO_BIDIR) || (v == LINE_LEVEL_BIDIR);
  endfunction : is_bidir

  // Two-entry buffer: the head entry is consumed one symbol per clock while transmitting.
  assign tx_ready = (buf_cnt_q != 2'(BUF_DEPTH));
  assign buf_pop = (buf_cnt_q != 2'h0);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      buf_cnt_q <= 2'h0;
      buf_sym_q[0] <= 2'h0;
      buf_sym_q[1] <= 2'h0;
      buf_last_q[0] <= 1'b0;
      buf_last_q[1] <= 1'b0;
    end
    else
    begin
      if (buf_pop)
      begin
        buf_sym_q[0] <= buf_sym_q[1];
        buf_last_q[0] <= buf_last_q[1];
      end
      if (tx_valid && tx_ready)
      begin
        if (buf_cnt_q == 2'h0 || (buf_cnt_q == 2'h1 && buf_pop))
        begin
          buf_sym_q[0] <= tx_symbol;
          buf_last_q[0] <= tx_last;
        end
        else
        begin
          buf_sym_q[1] <= tx_symbol;
          buf_last_q[1] <= tx_last;
        end
      end
      buf_cnt_q <= 2'(buf_cnt_q + 2'(tx_valid && tx_ready) - 2'(buf_pop));
    end
  end

  // Transmit phase: starts with the first symbol, ends after the symbol marked last or as soon as no symbol is popped.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      active_q <= 1'b0;
      plus_q <= 1'b1;
      minus_q <= 1'b0;
    end
    else if (buf_pop)
    begin
      active_q <= !buf_last_q[0];
      // Line-level variants encode zero as both lines low; data-zero drives data high.
      plus_q <= (buf_sym_q[0] == SYM_J) || (buf_sym_q[0] == SYM_ZERO && !is_line_level(variant_q));
      minus_q <= (buf_sym_q[0] == SYM_K) || (buf_sym_q[0] == SYM_ZERO && !is_line_level(variant_q));
    end
    else
    begin
      active_q <= 1'b0;
    end
  end

  // Enable low exactly while a symbol is on the pins.
  logic txing_q;
  logic zero_q;
  logic [SYNC_STAGES-1:0] txing_hist_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      txing_q <= 1'b0;
      zero_q <= 1'b0;
      txing_hist_q <= {SYNC_STAGES{1'b0}};
    end
    else
    begin
      txing_q <= buf_pop;
      txing_hist_q <= {txing_hist_q[SYNC_STAGES-2:0], txing_q};
      zero_q <= buf_pop && (buf_sym_q[0] == SYM_ZERO);
    end
  end

  assign tx_busy = txing_q || active_q || buf_pop;

  // Variant is latched only while idle and the enable is high.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      variant_q <= VARIANT_RESET;
    end
    else if (!tx_busy && !tx_valid)
    begin
      variant_q <= variant_sel;
    end
  end

  assign variant_active = variant_q;

  // Pin drive: data-zero puts data and zero request out, line-level puts plus and minus out.
  always_comb
  begin
    xcvr_tx_enable_n = !txing_q;
    if (is_line_level(variant_q))
    begin
      xcvr_data_plus_pin_out = plus_q;
      xcvr_zero_minus_pin_out = minus_q;
    end
    else
    begin
      xcvr_data_plus_pin_out = plus_q;
      xcvr_zero_minus_pin_out = zero_q;
    end
    // Shared pins turn round in bidirectional variants; dedicated outputs always drive.
    if (is_bidir(variant_q))
    begin
      xcvr_data_plus_pin_oe_n = !txing_q;
      xcvr_zero_minus_pin_oe_n = !txing_q;
    end
    else
    begin
      xcvr_data_plus_pin_oe_n = 1'b0;
      xcvr_zero_minus_pin_oe_n = 1'b0;
    end
  end

  // Two-flop synchronisers on every pin input.
  assign pins_raw = {xcvr_rx_diff_in, xcvr_rx_minus_in, xcvr_rx_plus_in,
                     xcvr_zero_minus_pin_in, xcvr_data_plus_pin_in};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // Receive decode per variant, updated only once the synchronisers hold samples taken with the enable high.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_plus <= 1'b0;
      rx_minus <= 1'b0;
      rx_diff <= 1'b0;
      rx_zero <= 1'b0;
    end
    else if (!txing_q && txing_hist_q == {SYNC_STAGES{1'b0}}) // Skips echoes of our own transmit phase.
    begin
      case (variant_q)
        DATA_ZERO_BIDIR:
        begin
          rx_diff <= sync2_q[0];
          rx_zero <= sync2_q[1];
          rx_plus <= 1'b0;
          rx_minus <= 1'b0;
        end
        DATA_ZERO_UNIDIR:
        begin
          rx_plus <= sync2_q[2];
          rx_minus <= sync2_q[3];
          rx_diff <= sync2_q[4];
          rx_zero <= !sync2_q[2] && !sync2_q[3];
        end
        LINE_LEVEL_BIDIR:
        begin
          rx_plus <= sync2_q[0];
          rx_minus <= sync2_q[1];
          rx_diff <= sync2_q[4];
          rx_zero <= !sync2_q[0] && !sync2_q[1];
        end
        default:
        begin
          rx_plus <= sync2_q[2];
          rx_minus <= sync2_q[3];
          rx_diff <= sync2_q[4];
          rx_zero <= !sync2_q[2] && !sync2_q[3];
        end
      endcase
    end
  end

  // Checks.
  sequence s_pop;
    buf_pop;
  endsequence

  a_enable_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_pop |=> !xcvr_tx_enable_n) else $error("enable not low after symbol");
  a_enable_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !buf_pop |=> xcvr_tx_enable_n) else $error("enable low with no symbol");
  a_data_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (buf_pop && buf_sym_q[0] == SYM_J) |=> xcvr_data_plus_pin_out) else $error("J not driven");
  a_zero_req: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (buf_pop && buf_sym_q[0] == SYM_ZERO && !is_line_level(variant_q)) |=> xcvr_zero_minus_pin_out)
    else $error("zero request missing");
  a_line_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (buf_pop && buf_sym_q[0] == SYM_ZERO && is_line_level(variant_q))
    |=> (!xcvr_data_plus_pin_out && !xcvr_zero_minus_pin_out)) else $error("line zero wrong");
  a_plus_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (buf_pop && buf_sym_q[0] == SYM_K && is_line_level(variant_q))
    |=> (!xcvr_data_plus_pin_out && xcvr_zero_minus_pin_out)) else $error("K levels wrong");
  a_bidir_turn: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_bidir(variant_q) |-> (xcvr_data_plus_pin_oe_n == xcvr_tx_enable_n)) else $error("turnaround wrong");
  a_minus_turn: assert property (@(posedge sys_clk) disable iff (sys_rst)
    is_bidir(variant_q) |-> (xcvr_zero_minus_pin_oe_n == xcvr_tx_enable_n)) else $error("minus turn wrong");
  a_variant_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    tx_busy |=> $stable(variant_q)) else $error("variant changed in transfer");
  a_rx_plus: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (xcvr_tx_enable_n && variant_q == LINE_LEVEL_UNIDIR) [*3]
    |=> rx_plus == $past(sync2_q[2])) else $error("rx plus wrong");

endmodule : xcvr_serial_port

`default_nettype wire

/* verification/xcvr_analog_model.sv */
// Behavioural model of the external full-speed transceiver at the port's pins.
`timescale 1ns/1ps
`default_nettype none

module xcvr_analog_model
  import xcvr_port_pkg::*;
(
  // Clock and configuration.
  input wire logic sys_clk,
  input wire logic [1:0] mode,
  // Line levels the transceiver returns.
  input wire logic lv_plus,
  input wire logic lv_minus,
  input wire logic lv_diff,
  input wire logic lv_zero,
  // Device side of the pins.
  input wire logic tx_enable_n,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic zero_out,
  input wire logic zero_oe_n,
  // Levels seen by the device.
  output logic data_in,
  output logic zero_in,
  output logic rx_plus_in,
  output logic rx_minus_in,
  output logic rx_diff_in
);
  logic flip_q = 1'b0;
  logic data_drv;
  logic zero_drv;

  // Undriven lines change every cycle, so a stale level never passes for a valid one.
  always @(posedge sys_clk)
  begin
    flip_q <= ~flip_q;
  end

  // Shared pins carry received levels only while the device listens.
  assign data_drv = (mode == DATA_ZERO_BIDIR) ? lv_diff : lv_plus;
  assign zero_drv = (mode == DATA_ZERO_BIDIR) ? lv_zero : lv_minus;
  assign data_in = !data_oe_n ? data_out : (tx_enable_n ? data_drv : flip_q);
  assign zero_in = !zero_oe_n ? zero_out : (tx_enable_n ? zero_drv : ~flip_q);
  assign rx_plus_in = tx_enable_n ? lv_plus : flip_q;
  assign rx_minus_in = tx_enable_n ? lv_minus : ~flip_q;
  assign rx_diff_in = tx_enable_n ? lv_diff : flip_q;
endmodule : xcvr_analog_model

`default_nettype wire

/* verification/xcvr_serial_port_tb.sv */
// Self-checking bench for the transceiver serial port.
`timescale 1ns/1ps
`default_nettype none

module xcvr_serial_port_tb;
  import xcvr_port_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] variant_sel = 2'h1;
  logic tx_valid = 1'b0;
  logic [1:0] tx_symbol = 2'h0;
  logic tx_last = 1'b0;
  logic lv_plus = 1'b0;
  logic lv_minus = 1'b0;
  logic lv_diff = 1'b0;
  logic lv_zero = 1'b0;
  logic tx_ready, rx_plus, rx_minus, rx_diff, rx_zero, tx_busy, en_n;
  logic d_in, d_out, d_oe_n, z_in, z_out, z_oe_n, rp, rm, rd;
  logic [1:0] variant_active;
  logic [2:0] hist[$];
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'h7ce9f9f2;
  int cycles = 0;

  xcvr_serial_port u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .variant_sel(variant_sel),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_symbol(tx_symbol), .tx_last(tx_last),
    .rx_plus(rx_plus), .rx_minus(rx_minus), .rx_diff(rx_diff), .rx_zero(rx_zero),
    .variant_active(variant_active), .tx_busy(tx_busy), .xcvr_tx_enable_n(en_n),
    .xcvr_data_plus_pin_in(d_in), .xcvr_data_plus_pin_out(d_out), .xcvr_data_plus_pin_oe_n(d_oe_n),
    .xcvr_zero_minus_pin_in(z_in), .xcvr_zero_minus_pin_out(z_out), .xcvr_zero_minus_pin_oe_n(z_oe_n),
    .xcvr_rx_plus_in(rp), .xcvr_rx_minus_in(rm), .xcvr_rx_diff_in(rd));

  xcvr_analog_model u_xcvr (.sys_clk(sys_clk), .mode(variant_active), .lv_plus(lv_plus), .lv_minus(lv_minus),
    .lv_diff(lv_diff), .lv_zero(lv_zero), .tx_enable_n(en_n), .data_out(d_out), .data_oe_n(d_oe_n),
    .zero_out(z_out), .zero_oe_n(z_oe_n), .data_in(d_in), .zero_in(z_in), .rx_plus_in(rp),
    .rx_minus_in(rm), .rx_diff_in(rd));

  // Clock at 200 MHz.
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // A hung run counts as a mismatch.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      wrap_up();
    end
  end

  task chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task chk_vec(input string name, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_vec

  // Expected {data pin, zero pin} for a symbol in a variant.
  function logic [1:0] exp_pins(input logic [1:0] v, input logic [1:0] s);
    if (v[1])
      return (s == SYM_J) ? 2'h2 : ((s == SYM_K) ? 2'h1 : 2'h0);
    return (s == SYM_J) ? 2'h2 : ((s == SYM_K) ? 2'h0 : 2'h3);
  endfunction : exp_pins

  task check_rx(input logic [1:0] v);
    chk_bit("rx_diff", lv_diff, rx_diff);
    if (v == DATA_ZERO_BIDIR)
      chk_bit("rx_zero", lv_zero, rx_zero);
    else
      chk_vec("rx levels", {lv_plus, lv_minus}, {rx_plus, rx_minus});
  endtask : check_rx

  task check_tx(input logic [1:0] v, input logic [2:0] h);
    chk_bit("tx_enable_n", ~h[2], en_n);
    chk_bit("tx_ready", 1'b1, tx_ready);
    chk_vec("pin oe_n", v[0] ? 2'h0 : {2{en_n}}, {d_oe_n, z_oe_n});
    if (h[2])
      chk_vec("tx pins", exp_pins(v, h[1:0]), {d_out, z_out});
  endtask : check_tx

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Each variant: latch it, receive, then a burst with a variant change attempted mid-transfer.
  initial
  begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int v = 0; v < 4; v++)
    begin
      variant_sel = v[1:0];
      lv_plus = 1'($random(seed));
      lv_minus = 1'($random(seed));
      lv_diff = 1'($random(seed));
      lv_zero = 1'($random(seed));
      repeat (5) @(negedge sys_clk);
      chk_vec("variant_active", v[1:0], variant_active);
      check_rx(v[1:0]);
      variant_sel = ~v[1:0];
      hist.delete();
      for (int i = 0; i < 42; i++)
      begin
        if (i >= 2)
        begin
          check_tx(v[1:0], hist[i - 2]);
          chk_bit("tx_busy", hist[i - 1][2] | hist[i - 2][2], tx_busy);
        end
        // Receive levels must hold through and after every transmit phase.
        check_rx(v[1:0]);
        if (i == 9)
          chk_vec("variant_active", v[1:0], variant_active);
        if (i == 10)
          variant_sel = v[1:0];
        tx_valid = (i < 12) || ((i < 40) && $random(seed));
        tx_symbol = 2'(($random(seed) & 32'h7fffffff) % 3);
        tx_last = 1'($random(seed));
        hist.push_back({tx_valid, tx_symbol});
        @(negedge sys_clk);
      end
      $display("test variant %0d done", v);
    end
    wrap_up();
  end
endmodule : xcvr_serial_port_tb

`default_nettype wire
